/* hw/ivs_unit.sv */
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps

module ivs_unit #(
	parameter int unsigned NFLAG     = ivs_pkg::NUM_FLAGS,
	parameter logic [7:0]  RST_VEC_LO = 8'h00
) (
	// clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// ahb-lite slave
	input  wire logic                   hsel,
	input  wire logic [ivs_pkg::ADDR_W-1:0] haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic [31:0]                 hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// core side
	input  wire ivs_pkg::ivs_cmd_t      core_cmd,
	input  wire ivs_pkg::ivs_ctx_t      core_ctx,
	input  wire logic                   core_fetch,
	input  wire logic [15:0]            core_fetch_addr,
	input  wire logic [7:0]             mem_rdata,
	output logic                        core_busy,
	output logic                        core_done,
	output ivs_pkg::ivs_mem_t           mem,
	output ivs_pkg::ivs_ctx_t           pulled,
	output logic [15:0]                 vec_addr,
	output logic                        vec_valid,
	// interrupt sources
	input  wire logic [NFLAG:1]         irq_flags,
	input  wire logic                   swi_req,
	output logic [NFLAG:1]              irq_ack,
	// watchdog and break
	output logic                        wdog_clear,
	output logic                        break_hit
);
	import ivs_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_PULL, ST_WAIT} ivs_state_t;

	logic             dph_wr_reg;   // write data phase
	logic             dph_rd_reg;   // read data phase
	logic             rd_done_reg;  // read wait state served
	logic [15:0]      dph_idx_reg;  // register index
	logic [31:0]      hrdata_reg;   // read data
	logic [7:0]       brk_hi_reg;   // break address high
	logic [7:0]       brk_lo_reg;   // break address low
	logic             brk_en_reg;   // break enable
	logic             brk_act_reg;  // break active
	logic             hit_reg;      // break match pulse
	logic             wdog_reg;     // watchdog clear pulse
	logic [15:0]      sp_reg;       // stack pointer
	ivs_state_t       state_reg;    // stacking state
	ivs_cmd_t         op_reg;       // command in progress
	logic [2:0]       cnt_reg;      // bytes left to move
	logic [39:0]      shift_reg;    // bytes to push
	ivs_mem_t         mem_reg;      // memory port
	logic             re_d_reg;     // read data valid
	ivs_ctx_t         pulled_reg;   // pulled bytes
	logic             done_reg;     // command finished
	logic [15:0]      vec_reg;      // chosen vector
	logic             vec_v_reg;    // vector ready
	logic [NFLAG:1]   ack_reg;      // source acknowledge
	logic             sel_any;      // a source is pending
	logic [4:0]       sel_idx;      // flag chosen
	logic [15:0]      sel_vec;      // its vector
	logic             addr_ok;      // address phase taken
	logic             wr_en;        // register write now
	logic             accept;       // command taken
	logic             brk_match;    // fetch hits break

	// ----------------------------------------
	// checks
	// ----------------------------------------
	if (NFLAG < 1 || NFLAG > 30) begin : g_chk
		$error("flag count out of range");
	end

	// ----------------------------------------
	// vector selection
	// ----------------------------------------
	ivs_vec_sel #(
		.NFLAG   (NFLAG)
	) u_sel (
		.flags   (irq_flags),
		.swi_req (swi_req),
		.any     (sel_any),
		.idx     (sel_idx),
		.vec     (sel_vec)
	);

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	assign addr_ok   = hsel & htrans[1] & hready;
	assign hreadyout = ~(dph_rd_reg & ~rd_done_reg);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;
	assign wr_en     = dph_wr_reg;

	// read word of a register index
	function automatic logic [31:0] rd_mux(input logic [15:0] i);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (i)
			IDX_BRK_HI: r = {24'h00_0000, brk_hi_reg};
			IDX_BRK_LO: r = {24'h00_0000, brk_lo_reg};
			IDX_BRK_SC: r = {24'h00_0000, brk_en_reg, brk_act_reg, 6'h00};
			IDX_WDOG:   r = {24'h00_0000, RST_VEC_LO};
			IDX_SP:     r = {16'h0000, sp_reg};
			IDX_VEC:    r = {16'h0000, vec_reg};
			IDX_PEND:   r = 32'({irq_flags, swi_req});
			default:    r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// data phase capture, held while stalled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_reg  <= 1'b0;
			dph_rd_reg  <= 1'b0;
			dph_idx_reg <= 16'h0000;
		end else if (hreadyout) begin
			dph_wr_reg  <= addr_ok & hwrite;
			dph_rd_reg  <= addr_ok & ~hwrite;
			dph_idx_reg <= haddr[ADDR_W-1:2];
		end
	end

	// one wait state on reads, data from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_done_reg <= 1'b0;
			hrdata_reg  <= 32'h0000_0000;
		end else if (hreadyout) begin
			rd_done_reg <= 1'b0;
		end else begin
			rd_done_reg <= 1'b1;
			hrdata_reg  <= rd_mux(dph_idx_reg);
		end
	end

	// ----------------------------------------
	// break registers
	// ----------------------------------------
	assign brk_match = core_fetch & brk_en_reg & (core_fetch_addr == {brk_hi_reg, brk_lo_reg});

	// address, enable and active flag; a hit wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brk_hi_reg  <= BRK_RST;
			brk_lo_reg  <= BRK_RST;
			brk_en_reg  <= 1'b0;
			brk_act_reg <= 1'b0;
			hit_reg     <= 1'b0;
		end else begin
			hit_reg <= brk_match;
			if (wr_en && dph_idx_reg == IDX_BRK_HI) begin
				brk_hi_reg <= hwdata[7:0];
			end
			if (wr_en && dph_idx_reg == IDX_BRK_LO) begin
				brk_lo_reg <= hwdata[7:0];
			end
			if (wr_en && dph_idx_reg == IDX_BRK_SC) begin
				brk_en_reg  <= hwdata[BRK_EN_BIT];
				brk_act_reg <= brk_match | (brk_act_reg & hwdata[BRK_ACT_BIT]);
			end else if (brk_match) begin
				brk_act_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// watchdog clear port
	// ----------------------------------------
	// any write value restarts the count, nothing is stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdog_reg <= 1'b0;
		end else begin
			wdog_reg <= wr_en & (dph_idx_reg == IDX_WDOG);
		end
	end

	// ----------------------------------------
	// stack pointer
	// ----------------------------------------
	// full 16-bit pointer; a bus write wins over stacking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_reg <= SP_RST;
		end else if (wr_en && dph_idx_reg == IDX_SP) begin
			sp_reg <= hwdata[15:0];
		end else if (state_reg == ST_PUSH) begin
			sp_reg <= sp_reg - 16'h0001;
		end else if (state_reg == ST_PULL) begin
			sp_reg <= sp_reg + 16'h0001;
		end
	end

	// ----------------------------------------
	// stacking engine
	// ----------------------------------------
	assign accept    = (state_reg == ST_IDLE) & (core_cmd != IVS_CMD_NONE) &
	                   ((core_cmd != IVS_CMD_INT) | sel_any);
	assign core_busy = (state_reg != ST_IDLE);

	// command sequencing and byte counting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			op_reg    <= IVS_CMD_NONE;
			cnt_reg   <= 3'h0;
			shift_reg <= 40'h00_0000_0000;
			done_reg  <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (accept) begin
						op_reg <= core_cmd;
						// high index byte has no slot in the context
						shift_reg <= core_ctx;
						case (core_cmd)
							IVS_CMD_INT: begin
								cnt_reg   <= INT_BYTES;
								state_reg <= ST_PUSH;
							end
							IVS_CMD_CALL: begin
								cnt_reg   <= CALL_BYTES;
								state_reg <= ST_PUSH;
							end
							IVS_CMD_RTI: begin
								cnt_reg   <= INT_BYTES;
								state_reg <= ST_PULL;
							end
							default: begin
								cnt_reg   <= CALL_BYTES;
								state_reg <= ST_PULL;
							end
						endcase
					end
				end
				ST_PUSH, ST_PULL: begin
					shift_reg <= {8'h00, shift_reg[39:8]};
					cnt_reg   <= cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// last write issued or last read byte caught
					if (!mem_reg.we && !mem_reg.re && !re_d_reg) begin
						done_reg  <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// memory port: write then decrement, increment then read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_reg <= '0;
		end else begin
			mem_reg.we <= 1'b0;
			mem_reg.re <= 1'b0;
			if (state_reg == ST_PUSH) begin
				mem_reg.addr  <= sp_reg;
				mem_reg.wdata <= shift_reg[7:0];
				mem_reg.we    <= 1'b1;
			end else if (state_reg == ST_PULL) begin
				mem_reg.addr <= sp_reg + 16'h0001;
				mem_reg.re   <= 1'b1;
			end
		end
	end

	// pulled bytes arrive a cycle after each read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			re_d_reg   <= 1'b0;
			pulled_reg <= '0;
		end else begin
			re_d_reg <= mem_reg.re;
			if (re_d_reg) begin
				pulled_reg <= {pulled_reg[31:0], mem_rdata};
			end
		end
	end

	// ----------------------------------------
	// vector and acknowledge
	// ----------------------------------------
	// reset vector shown first, then the chosen source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vec_reg   <= VEC_RESET;
			vec_v_reg <= 1'b1;
			ack_reg   <= '0;
		end else begin
			ack_reg <= '0;
			if (accept && core_cmd == IVS_CMD_INT) begin
				vec_reg   <= sel_vec;
				vec_v_reg <= 1'b0;
				if (!swi_req) begin
					ack_reg[sel_idx] <= 1'b1;
				end
			end else if (state_reg == ST_WAIT && op_reg == IVS_CMD_INT && !mem_reg.we) begin
				vec_v_reg <= 1'b1;
			end else if (accept) begin
				vec_v_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign core_done  = done_reg;
	assign mem        = mem_reg;
	assign pulled     = pulled_reg;
	assign vec_addr   = vec_reg;
	assign vec_valid  = vec_v_reg;
	assign irq_ack    = ack_reg;
	assign wdog_clear = wdog_reg;
	assign break_hit  = hit_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_int_go;
		accept && core_cmd == IVS_CMD_INT;
	endsequence

	sequence s_call_go;
		accept && core_cmd == IVS_CMD_CALL;
	endsequence

	a_int_five_push: assert property (s_int_go |-> ##2 mem.we [*5] ##1 !mem.we)
		else $error("interrupt entry did not push five bytes");

	a_call_two_push: assert property (s_call_go |-> ##2 mem.we [*2] ##1 !mem.we)
		else $error("call did not push two bytes");

	a_sp_push_dec: assert property (mem.we |-> sp_reg == mem.addr - 16'h0001 || $past(wr_en))
		else $error("pointer did not drop after a push");

	a_sp_pull_inc: assert property (mem.re |-> sp_reg == mem.addr || $past(wr_en))
		else $error("pointer did not rise before a pull");

	a_wdog_any_write: assert property (wr_en && dph_idx_reg == IDX_WDOG |=> wdog_clear)
		else $error("watchdog clear missed");

	a_wdog_read_lo: assert property (dph_rd_reg && !rd_done_reg && dph_idx_reg == IDX_WDOG
		|=> hrdata == {24'h00_0000, RST_VEC_LO})
		else $error("top byte read is not reset vector low");

	a_brk_sc_zero: assert property (dph_rd_reg && !rd_done_reg && dph_idx_reg == IDX_BRK_SC
		|=> hrdata[5:0] == 6'h00 && hrdata[7] == brk_en_reg)
		else $error("break control read wrong");

	a_rtc_lowest: assert property (s_int_go and (!swi_req && irq_flags == {1'b1, {(NFLAG-1){1'b0}}})
		|=> vec_addr == VEC_RTC)
		else $error("clock vector wrong");

	a_flag_prio: assert property ((s_int_go and (!swi_req && irq_flags[1]))
		|=> vec_addr == VEC_FLAG_BASE - 16'h0002 && irq_ack[1])
		else $error("lowest flag not chosen first");

	a_swi_above: assert property ((s_int_go and swi_req) |=> vec_addr == VEC_SWI && irq_ack == '0)
		else $error("software interrupt not ranked first");

endmodule // ivs_unit

/* hw/ivs_pkg.sv */
package ivs_pkg;

	// ----------------------------------------
	// register indexes (byte address = 4 * index)
	// ----------------------------------------
	localparam int unsigned ADDR_W      = 18;
	localparam logic [15:0] IDX_BRK_HI  = 16'hfe0c; // break address high
	localparam logic [15:0] IDX_BRK_LO  = 16'hfe0d; // break address low
	localparam logic [15:0] IDX_BRK_SC  = 16'hfe0e; // break status and control
	localparam logic [15:0] IDX_WDOG    = 16'hffff; // watchdog clear port
	localparam logic [15:0] IDX_SP      = 16'hfe10; // stack pointer
	localparam logic [15:0] IDX_VEC     = 16'hfe11; // last vector chosen
	localparam logic [15:0] IDX_PEND    = 16'hfe12; // pending requests

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int unsigned BRK_EN_BIT  = 7;        // break_enable_bit
	localparam int unsigned BRK_ACT_BIT = 6;        // break_active_bit
	localparam logic [7:0]  BRK_RST     = 8'h00;
	localparam logic [15:0] SP_RST      = 16'h00ff;

	// ----------------------------------------
	// vectors: flag n sits at VEC_FLAG_BASE - 2n
	// ----------------------------------------
	localparam int unsigned NUM_FLAGS     = 17;
	localparam logic [15:0] VEC_RESET     = 16'hfffe;
	localparam logic [15:0] VEC_SWI       = 16'hfffc;
	localparam logic [15:0] VEC_FLAG_BASE = 16'hfffc;
	localparam logic [15:0] VEC_RTC       = 16'hffda;

	// ----------------------------------------
	// stacking byte counts
	// ----------------------------------------
	localparam logic [2:0]  INT_BYTES  = 3'h5;
	localparam logic [2:0]  CALL_BYTES = 3'h2;

	// core command
	typedef enum logic [2:0] {
		IVS_CMD_NONE,
		IVS_CMD_INT,
		IVS_CMD_CALL,
		IVS_CMD_RTI,
		IVS_CMD_RTS
	} ivs_cmd_t;

	// cpu context, msb first; pcl is pushed first
	typedef struct packed {
		logic [7:0] ccr;
		logic [7:0] a;
		logic [7:0] x;
		logic [7:0] pch;
		logic [7:0] pcl;
	} ivs_ctx_t;

	// stack memory port
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} ivs_mem_t;

endpackage

/* hw/ivs_vec_sel.sv */
`timescale 1ns/1ps

module ivs_vec_sel #(
	parameter int unsigned NFLAG = ivs_pkg::NUM_FLAGS
) (
	// requests
	input  wire logic [NFLAG:1] flags,
	input  wire logic           swi_req,
	// choice
	output logic                any,
	output logic [4:0]          idx,
	output logic [15:0]         vec
);
	import ivs_pkg::*;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	if (NFLAG < 1 || NFLAG > 30) begin : g_chk
		$error("flag count out of range");
	end

	// lowest set index wins, zero when none
	function automatic logic [4:0] first_set(input logic [NFLAG:1] f);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NFLAG; i >= 1; i--) begin
			if (f[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// selection
	// ----------------------------------------
	// software interrupt ranks above every flag
	always_comb begin
		idx = first_set(flags);
		any = swi_req | (|flags);
		if (swi_req) begin
			vec = VEC_SWI;
		end else begin
			vec = VEC_FLAG_BASE - {10'h000, idx, 1'b0};
		end
	end

endmodule // ivs_vec_sel

/* testbench/ivs_stack_mem.sv */
`timescale 1ns/1ps

// ----------------------------------------
// stack ram seen by the stacking engine
// ----------------------------------------
module ivs_stack_mem (
	// clock
	input  wire logic              hclk,
	// stack port from the unit
	input  wire ivs_pkg::ivs_mem_t mem,
	output logic [7:0]             mem_rdata,
	// traffic counters for the bench
	output int                     wr_cnt,
	output int                     rd_cnt
);
	import ivs_pkg::*;

	logic [7:0] ram [0:65535]; // full 64k byte space

	initial begin
		wr_cnt = 0;
		rd_cnt = 0;
		mem_rdata = 8'h00;
	end

	// byte writes land at once, reads answer one cycle later
	always @(posedge hclk) begin
		if (mem.we) begin
			ram[mem.addr] <= mem.wdata;
			wr_cnt <= wr_cnt + 1;
		end
		// outside a read the bus shows a changing pattern, not stale data
		if (mem.re) begin
			mem_rdata <= ram[mem.addr];
			rd_cnt <= rd_cnt + 1;
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // ivs_stack_mem

/* testbench/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
	import ivs_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_fetch;
	logic core_busy, core_done, swi_req, vec_valid, wdog_clear, break_hit;
	logic [17:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic [15:0] core_fetch_addr, vec_addr;
	logic [7:0]  mem_rdata;
	logic [17:1] irq_flags, irq_ack, ack_last;
	ivs_cmd_t    core_cmd;
	ivs_ctx_t    core_ctx, pulled;
	ivs_mem_t    mem;
	int          n_errors, checks_done, cyc, wr_cnt, rd_cnt, wd_cnt, hit_cnt;
	// documented vector of each flag, lowest index first
	localparam logic [15:0] VTAB [1:17] = '{16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
		16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffde, 16'hffdc, 16'hffda};

	assign hready = hreadyout; // single slave

	ivs_unit #(.RST_VEC_LO(8'h5a)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .core_cmd(core_cmd), .core_ctx(core_ctx), .core_fetch(core_fetch),
		.core_fetch_addr(core_fetch_addr), .mem_rdata(mem_rdata), .core_busy(core_busy), .core_done(core_done),
		.mem(mem), .pulled(pulled), .vec_addr(vec_addr), .vec_valid(vec_valid), .irq_flags(irq_flags),
		.swi_req(swi_req), .irq_ack(irq_ack), .wdog_clear(wdog_clear), .break_hit(break_hit));

	ivs_stack_mem u_mem (.hclk(hclk), .mem(mem), .mem_rdata(mem_rdata), .wr_cnt(wr_cnt), .rd_cnt(rd_cnt));

	always #2.5 hclk = ~hclk;

	// pulse monitors and hang guard
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (irq_ack != '0) ack_last <= irq_ack;
		if (wdog_clear) wd_cnt <= wd_cnt + 1;
		if (break_hit) hit_cnt <= hit_cnt + 1;
		if (cyc == 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {idx, 2'b00};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0000_0000, "response");
	endtask

	task automatic run_cmd(input ivs_cmd_t c, input ivs_ctx_t x);
		@(posedge hclk);
		core_cmd <= c;
		core_ctx <= x;
		@(posedge hclk);
		core_cmd <= IVS_CMD_NONE;
		do @(posedge hclk); while (core_done !== 1'b1);
	endtask

	task automatic fetch(input logic [15:0] a);
		@(posedge hclk);
		core_fetch <= 1'b1;
		core_fetch_addr <= a;
		@(posedge hclk);
		core_fetch <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_values;
		ahb(0, IDX_SP, 0);
		chk(rd, 32'h0000_00ff, "sp reset");
		ahb(0, IDX_BRK_SC, 0);
		chk(rd, 32'h0000_0000, "break ctl reset");
		chk({16'h0, vec_addr}, 32'h0000_fffe, "reset vector");
		chk({31'h0, vec_valid}, 32'h0000_0001, "reset vector valid");
	endtask

	task automatic t_break_regs;
		ahb(1, IDX_BRK_HI, 32'h0000_0012);
		ahb(1, IDX_BRK_LO, 32'h0000_0034);
		ahb(1, IDX_BRK_SC, 32'hffff_ffff);
		ahb(0, IDX_BRK_HI, 0);
		chk(rd, 32'h0000_0012, "break high");
		ahb(0, IDX_BRK_LO, 0);
		chk(rd, 32'h0000_0034, "break low");
		ahb(0, IDX_BRK_SC, 0);
		chk(rd, 32'h0000_0080, "break ctl rw bits");
		ahb(0, 16'hfe20, 0);
		chk(rd, 32'h0000_0000, "unmapped read");
	endtask

	task automatic t_watchdog;
		int w;
		w = wd_cnt;
		ahb(1, IDX_WDOG, 32'h0000_00a5);
		ahb(1, IDX_WDOG, 32'h0000_0000);
		// pulse shows one edge later, the monitor counts it one edge after that
		repeat (2) @(posedge hclk);
		chk(wd_cnt - w, 2, "watchdog clears");
		ahb(0, IDX_WDOG, 0);
		chk(rd, 32'h0000_005a, "top byte read");
	endtask

	task automatic t_break_match;
		int h;
		h = hit_cnt;
		fetch(16'h1235);
		chk(hit_cnt - h, 0, "no hit on mismatch");
		fetch(16'h1234);
		chk(hit_cnt - h, 1, "hit on match");
		ahb(0, IDX_BRK_SC, 0);
		chk(rd, 32'h0000_00c0, "active bit set");
		ahb(1, IDX_BRK_SC, 0);
		fetch(16'h1234);
		ahb(0, IDX_BRK_SC, 0);
		chk(rd, 32'h0000_0000, "cleared and disabled");
		chk(hit_cnt - h, 1, "no hit when disabled");
	endtask

	task automatic t_vector_table;
		logic [17:1] f;
		int w;
		for (int n = 1; n <= 17; n++) begin
			f = '0;
			f[n] = 1'b1;
			irq_flags <= f;
			w = wr_cnt;
			run_cmd(IVS_CMD_INT, '0);
			chk({16'h0, vec_addr}, {16'h0, VTAB[n]}, "flag vector");
			chk({15'h0, ack_last}, {15'h0, f}, "ack one-hot");
			chk(wr_cnt - w, 5, "int push count");
			chk({31'h0, vec_valid}, 32'h0000_0001, "vector valid after entry");
		end
		irq_flags <= '0;
		swi_req <= 1'b1;
		run_cmd(IVS_CMD_INT, '0);
		swi_req <= 1'b0;
		chk({16'h0, vec_addr}, 32'h0000_fffc, "swi vector");
		ahb(0, IDX_SP, 0);
		chk(rd, 32'h0000_00a5, "sp after 18 entries");
	endtask

	task automatic t_priority;
		irq_flags <= 17'h1_ffff;
		swi_req <= 1'b1;
		run_cmd(IVS_CMD_INT, '0);
		chk({16'h0, vec_addr}, 32'h0000_fffc, "swi over flags");
		swi_req <= 1'b0;
		run_cmd(IVS_CMD_INT, '0);
		chk({16'h0, vec_addr}, 32'h0000_fffa, "lowest index wins");
		irq_flags <= 17'h1_8000;
		run_cmd(IVS_CMD_INT, '0);
		chk({16'h0, vec_addr}, 32'h0000_ffdc, "clock ranks last");
		irq_flags <= '0;
	endtask

	task automatic t_stacking;
		ivs_ctx_t c;
		logic [7:0] e [5];
		int w;
		c = '{ccr: 8'hc1, a: 8'ha2, x: 8'h73, pch: 8'h84, pcl: 8'h95};
		e = '{8'h95, 8'h84, 8'h73, 8'ha2, 8'hc1};
		ahb(1, IDX_SP, 32'h0000_0200);
		ahb(0, IDX_SP, 0);
		chk(rd, 32'h0000_0200, "sp wide");
		swi_req <= 1'b1;
		run_cmd(IVS_CMD_INT, c);
		swi_req <= 1'b0;
		for (int i = 0; i < 5; i++) chk({24'h0, u_mem.ram[16'h0200 - i]}, {24'h0, e[i]}, "stacked byte");
		w = rd_cnt;
		run_cmd(IVS_CMD_RTI, '0);
		// context is 40 bits: compare in two words so ccr is not cut off
		chk(pulled[31:0], c[31:0], "rti context low");
		chk({24'h0, pulled[39:32]}, {24'h0, c.ccr}, "rti context ccr");
		chk(rd_cnt - w, 5, "rti pull count");
		ahb(0, IDX_SP, 0);
		chk(rd, 32'h0000_0200, "sp after rti");
		w = wr_cnt;
		run_cmd(IVS_CMD_CALL, '{ccr: 8'h00, a: 8'h00, x: 8'h00, pch: 8'hbe, pcl: 8'hef});
		chk(wr_cnt - w, 2, "call push count");
		chk({16'h0, u_mem.ram[16'h0200], u_mem.ram[16'h01ff]}, 32'h0000_efbe, "return address");
		ahb(0, IDX_SP, 0);
		chk(rd, 32'h0000_01fe, "sp after call");
		run_cmd(IVS_CMD_RTS, '0);
		chk({16'h0, pulled[15:0]}, 32'h0000_beef, "rts address");
		chk({31'h0, core_busy}, 32'h0000_0000, "idle after return");
		ahb(0, IDX_SP, 0);
		chk(rd, 32'h0000_0200, "sp after rts");
	endtask

	task automatic tally_and_finish;
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		hclk = 0; hresetn = 0; hsel = 0; haddr = '0; htrans = 2'b00; hwrite = 0; hsize = 3'h2;
		hwdata = '0; core_cmd = IVS_CMD_NONE; core_ctx = '0; core_fetch = 0; core_fetch_addr = '0;
		irq_flags = '0; swi_req = 0; ack_last = '0; n_errors = 0; checks_done = 0; cyc = 0;
		wd_cnt = 0; hit_cnt = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_values();
		t_break_regs();
		t_watchdog();
		t_break_match();
		t_vector_table();
		t_priority();
		t_stacking();
		tally_and_finish();
	end
endmodule // tb_top
